// >>> rtl/adcseq_defs.vh
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH

// Register indices
`define ADCSEQ_ADDR_W 4
`define ADCSEQ_REG_RES_HI 4'h0
`define ADCSEQ_REG_RES_LO 4'h1
`define ADCSEQ_REG_CTRL0 4'h2
`define ADCSEQ_REG_CTRL1 4'h3
`define ADCSEQ_REG_CTRL2 4'h4
`define ADCSEQ_REG_IRQ 4'h5
`define ADCSEQ_REG_CMP_MODE 4'h6
`define ADCSEQ_REG_PORT_LO 4'h7
`define ADCSEQ_REG_PORT_HI 4'h8

// channel_and_run_control fields
`define ADCSEQ_ENABLE_BIT 0
`define ADCSEQ_GO_BIT 1
`define ADCSEQ_CHS_LSB 2
`define ADCSEQ_CHS_MSB 5

// reference_and_pin_config fields
`define ADCSEQ_PCFG_LSB 0
`define ADCSEQ_PCFG_MSB 3
`define ADCSEQ_POS_REFERENCE_SELECT_BIT 4
`define ADCSEQ_NEG_REFERENCE_SELECT_BIT 5
`define ADCSEQ_CTRL1_W 6

// timing_and_format_config fields
`define ADCSEQ_ADCS_LSB 0
`define ADCSEQ_ADCS_MSB 2
`define ADCSEQ_ACQT_LSB 3
`define ADCSEQ_ACQT_MSB 5
`define ADCSEQ_RESULT_JUSTIFY_SELECT_BIT 7

// Interrupt flag register fields
`define ADCSEQ_FLAG_BIT 0
`define ADCSEQ_IRQ_EN_BIT 1

// Modes and codes
`define ADCSEQ_CMP_MODE_TRIG 4'hb
`define ADCSEQ_ACQT_MANUAL 3'h0
`define ADCSEQ_RESET_BYTE 8'h00

// Timing, in conversion bit periods or clocks
`define ADCSEQ_CNT_W 5
`define ADCSEQ_CONV_TADS 5'd11
`define ADCSEQ_SAR_STEPS 5'd10
`define ADCSEQ_RECOV_TADS 5'd2
`define ADCSEQ_INSTR_CLKS 5'd4

// Conversion clock divisors in system clocks
`define ADCSEQ_DIV_W 7
`define ADCSEQ_DIV_2 7'd2
`define ADCSEQ_DIV_4 7'd4
`define ADCSEQ_DIV_8 7'd8
`define ADCSEQ_DIV_16 7'd16
`define ADCSEQ_DIV_32 7'd32
`define ADCSEQ_DIV_64 7'd64
// Internal RC period of 1.2 us in 40 ns clocks, sized to the divider
`define ADCSEQ_RC_TAD_CLKS 7'd30

// Converter data
`define ADCSEQ_RES_W 10
`define ADCSEQ_RES_MSB_ONLY 10'h200
`define ADCSEQ_PORT_W 16
`define ADCSEQ_ALL_ANALOG 16'hffff

`endif

// >>> rtl/adcseq_tad_gen.v
`timescale 1ns/1ps
`include "adcseq_defs.vh"

module adcseq_tad_gen
(
  input wire clk,
  input wire reset_n,
  input wire restart,
  input wire [2:0] clk_select,
  output reg tad_tick_ff
);

  reg [`ADCSEQ_DIV_W-1:0] count_ff;
  wire [`ADCSEQ_DIV_W-1:0] last;
  wire wrap;

  // Any x11 code picks the internal RC period, usable in sleep
  function [`ADCSEQ_DIV_W-1:0] tad_div;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tad_div = `ADCSEQ_DIV_2;
        3'h4: tad_div = `ADCSEQ_DIV_4;
        3'h1: tad_div = `ADCSEQ_DIV_8;
        3'h5: tad_div = `ADCSEQ_DIV_16;
        3'h2: tad_div = `ADCSEQ_DIV_32;
        3'h6: tad_div = `ADCSEQ_DIV_64;
        default: tad_div = `ADCSEQ_RC_TAD_CLKS;
      endcase
    end
  endfunction

  assign last = tad_div(clk_select) - 7'd1;
  assign wrap = (count_ff >= last);

  // Restart realigns the period to each phase change
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      count_ff <= {`ADCSEQ_DIV_W{1'b0}};
      tad_tick_ff <= 1'b0;
    end
    else
    begin
      count_ff <= (restart || wrap) ? {`ADCSEQ_DIV_W{1'b0}} : count_ff + 7'd1;
      tad_tick_ff <= wrap && !restart;
    end
  end

endmodule // adcseq_tad_gen

// >>> rtl/adcseq_sar.v
`timescale 1ns/1ps
`include "adcseq_defs.vh"

module adcseq_sar
(
  input wire clk,
  input wire reset_n,
  input wire start,
  input wire step,
  input wire cmp_above,
  output reg [`ADCSEQ_RES_W-1:0] trial_ff
);

  reg [`ADCSEQ_RES_W-1:0] mask_ff;

  // Keep the trial bit while the input sits above the trial level
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      trial_ff <= {`ADCSEQ_RES_W{1'b0}};
      mask_ff <= {`ADCSEQ_RES_W{1'b0}};
    end
    else if (start)
    begin
      trial_ff <= `ADCSEQ_RES_MSB_ONLY;
      mask_ff <= `ADCSEQ_RES_MSB_ONLY;
    end
    else if (step)
    begin
      trial_ff <= (cmp_above ? trial_ff : (trial_ff & ~mask_ff)) | (mask_ff >> 1);
      mask_ff <= mask_ff >> 1;
    end
  end

endmodule // adcseq_sar

// >>> rtl/adcseq_top.v
`timescale 1ns/1ps
`include "adcseq_defs.vh"

// What this block does
// - Manual acquisition start waits one instruction cycle
// - Selected pin sampled regardless of direction
// - Port reads zero on analog-configured pins
// - Code 010 gives four-period acquisition first
// - Clearing start bit aborts conversion immediately
// - Abort leaves result pair untouched
// - Two-period wait after completion or abort
// - Acquisition resumes automatically after the wait
// - Capacitor array discharged before every sample
// - Compare event in mode 1011 sets start
// - Special event in mode 1011 clears trigger timer
// - Disabled converter ignores event, timer still cleared
// - Completion loads result, clears start, sets flag
// - Conversion lasts eleven bit periods
// - Acquisition code zero converts after one instruction cycle
module adcseq_top
(
  input wire clk,
  input wire reset_n,
  input wire [`ADCSEQ_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata_ff,
  input wire cmp_above,
  input wire [`ADCSEQ_PORT_W-1:0] port_pins,
  input wire special_event,
  output reg [3:0] channel_sel_ff,
  output reg sample_switch_ff,
  output reg discharge_ff,
  output reg converting_ff,
  output wire [`ADCSEQ_RES_W-1:0] dac_code,
  output reg pos_reference_select_ff,
  output reg neg_reference_select_ff,
  output reg trigger_timer_clear_ff,
  output reg conversion_done_irq_ff
);

  localparam [6:0] ST_OFF = 7'b0000001;
  localparam [6:0] ST_DISCH = 7'b0000010;
  localparam [6:0] ST_SAMPLE = 7'b0000100;
  localparam [6:0] ST_DELAY = 7'b0001000;
  localparam [6:0] ST_ACQ = 7'b0010000;
  localparam [6:0] ST_CONV = 7'b0100000;
  localparam [6:0] ST_RECOV = 7'b1000000;

  reg [6:0] state_ff;
  reg [6:0] nxt_state;
  reg [`ADCSEQ_CNT_W-1:0] cnt_ff;
  reg [`ADCSEQ_CNT_W-1:0] nxt_cnt;
  reg [7:0] res_hi_ff;
  reg [7:0] res_lo_ff;
  reg converter_enable_ff;
  reg go_ff;
  reg nxt_go;
  reg [3:0] input_channel_select_ff;
  reg [`ADCSEQ_CTRL1_W-1:0] ctrl1_ff;
  reg [7:0] ctrl2_ff;
  reg conversion_done_irq_flag_ff;
  reg nxt_flag;
  reg conversion_done_irq_enable_ff;
  reg [3:0] compare_mode_field_ff;
  reg cmp_meta_ff;
  reg cmp_sync_ff;
  reg [`ADCSEQ_PORT_W-1:0] port_meta_ff;
  reg [`ADCSEQ_PORT_W-1:0] port_sync_ff;
  reg sar_start;
  reg sar_step;
  reg conv_done;
  reg abort;
  reg [7:0] rd_mux;
  reg [7:0] nxt_res_hi;
  reg [7:0] nxt_res_lo;

  wire tad_tick;
  wire [2:0] acquisition_time_select;
  wire [2:0] conversion_clock_select;
  wire result_justify_select;
  wire [3:0] analog_pin_config;
  wire wr_ctrl0;
  wire event_is_trigger;
  wire trig_take;
  wire [`ADCSEQ_PORT_W-1:0] port_read;

  assign acquisition_time_select = ctrl2_ff[`ADCSEQ_ACQT_MSB:`ADCSEQ_ACQT_LSB];
  assign conversion_clock_select = ctrl2_ff[`ADCSEQ_ADCS_MSB:`ADCSEQ_ADCS_LSB];
  assign result_justify_select = ctrl2_ff[`ADCSEQ_RESULT_JUSTIFY_SELECT_BIT];
  assign analog_pin_config = ctrl1_ff[`ADCSEQ_PCFG_MSB:`ADCSEQ_PCFG_LSB];
  assign wr_ctrl0 = wr_en && (addr == `ADCSEQ_REG_CTRL0);

  // Acquisition length in bit periods, code 000 means none
  function [`ADCSEQ_CNT_W-1:0] acq_tads;
    input [2:0] code;
    begin
      case (code)
        3'h1: acq_tads = 5'd2;
        3'h2: acq_tads = 5'd4;
        3'h3: acq_tads = 5'd6;
        3'h4: acq_tads = 5'd8;
        3'h5: acq_tads = 5'd12;
        3'h6: acq_tads = 5'd16;
        3'h7: acq_tads = 5'd20;
        default: acq_tads = 5'd0;
      endcase
    end
  endfunction

  // Higher config codes leave fewer channels analog, from AN0 up
  function [`ADCSEQ_PORT_W-1:0] analog_mask;
    input [3:0] cfg;
    begin
      analog_mask = `ADCSEQ_ALL_ANALOG >> cfg;
    end
  endfunction

  assign port_read = port_sync_ff & ~analog_mask(analog_pin_config);

  // Timer is cleared even while the converter is off
  assign event_is_trigger = special_event && (compare_mode_field_ff == `ADCSEQ_CMP_MODE_TRIG);
  assign trig_take = event_is_trigger && converter_enable_ff;

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    sar_start = 1'b0;
    sar_step = 1'b0;
    conv_done = 1'b0;
    abort = 1'b0;
    case (state_ff)
      ST_OFF:
      begin
        nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
        if (converter_enable_ff)
          nxt_state = ST_DISCH;
      end
      ST_DISCH:
      begin
        if (tad_tick)
          nxt_state = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
        if (go_ff && acquisition_time_select == `ADCSEQ_ACQT_MANUAL)
          nxt_state = ST_DELAY;
        else if (go_ff)
          nxt_state = ST_ACQ;
      end
      ST_DELAY:
      begin
        if (!go_ff)
          abort = 1'b1;
        else if (cnt_ff == `ADCSEQ_INSTR_CLKS - 5'd1)
        begin
          nxt_state = ST_CONV;
          nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
          sar_start = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 5'd1;
      end
      ST_ACQ:
      begin
        if (!go_ff)
          abort = 1'b1;
        else if (tad_tick && cnt_ff == acq_tads(acquisition_time_select) - 5'd1)
        begin
          nxt_state = ST_CONV;
          nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
          sar_start = 1'b1;
        end
        else if (tad_tick)
          nxt_cnt = cnt_ff + 5'd1;
      end
      ST_CONV:
      begin
        if (!go_ff)
          abort = 1'b1;
        else if (tad_tick && cnt_ff == `ADCSEQ_CONV_TADS - 5'd1)
        begin
          conv_done = 1'b1;
          nxt_state = ST_RECOV;
          nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
        end
        else if (tad_tick)
        begin
          sar_step = (cnt_ff < `ADCSEQ_SAR_STEPS);
          nxt_cnt = cnt_ff + 5'd1;
        end
      end
      ST_RECOV:
      begin
        if (tad_tick && cnt_ff == `ADCSEQ_RECOV_TADS - 5'd1)
          nxt_state = ST_DISCH;
        else if (tad_tick)
          nxt_cnt = cnt_ff + 5'd1;
      end
      default:
      begin
        nxt_state = ST_OFF;
        nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
      end
    endcase
    if (abort)
    begin
      nxt_state = ST_RECOV;
      nxt_cnt = {`ADCSEQ_CNT_W{1'b0}};
    end
    if (!converter_enable_ff)
      nxt_state = ST_OFF;
  end

  always @*
  begin
    nxt_go = go_ff;
    if (wr_ctrl0)
      nxt_go = wdata[`ADCSEQ_GO_BIT] & wdata[`ADCSEQ_ENABLE_BIT];
    if (conv_done)
      nxt_go = 1'b0;
    if (trig_take)
      nxt_go = 1'b1;
    nxt_flag = conversion_done_irq_flag_ff;
    if (wr_en && addr == `ADCSEQ_REG_IRQ)
      nxt_flag = wdata[`ADCSEQ_FLAG_BIT];
    if (conv_done)
      nxt_flag = 1'b1;
    nxt_res_hi = res_hi_ff;
    nxt_res_lo = res_lo_ff;
    if (wr_en && addr == `ADCSEQ_REG_RES_HI)
      nxt_res_hi = wdata;
    if (wr_en && addr == `ADCSEQ_REG_RES_LO)
      nxt_res_lo = wdata;
    // Only a finished conversion reaches the pair, never an aborted one
    if (conv_done && result_justify_select)
    begin
      nxt_res_hi = {6'h00, dac_code[9:8]};
      nxt_res_lo = dac_code[7:0];
    end
    else if (conv_done)
    begin
      nxt_res_hi = dac_code[9:2];
      nxt_res_lo = {dac_code[1:0], 6'h00};
    end
  end

  always @*
  begin
    case (addr)
      `ADCSEQ_REG_RES_HI: rd_mux = res_hi_ff;
      `ADCSEQ_REG_RES_LO: rd_mux = res_lo_ff;
      `ADCSEQ_REG_CTRL0: rd_mux = {2'h0, input_channel_select_ff, go_ff, converter_enable_ff};
      `ADCSEQ_REG_CTRL1: rd_mux = {2'h0, ctrl1_ff};
      `ADCSEQ_REG_CTRL2: rd_mux = ctrl2_ff;
      `ADCSEQ_REG_IRQ: rd_mux = {6'h00, conversion_done_irq_enable_ff,
                                 conversion_done_irq_flag_ff};
      `ADCSEQ_REG_CMP_MODE: rd_mux = {4'h0, compare_mode_field_ff};
      `ADCSEQ_REG_PORT_LO: rd_mux = port_read[7:0];
      `ADCSEQ_REG_PORT_HI: rd_mux = port_read[15:8];
      default: rd_mux = `ADCSEQ_RESET_BYTE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_OFF;
      cnt_ff <= {`ADCSEQ_CNT_W{1'b0}};
      res_hi_ff <= `ADCSEQ_RESET_BYTE;
      res_lo_ff <= `ADCSEQ_RESET_BYTE;
      converter_enable_ff <= 1'b0;
      go_ff <= 1'b0;
      input_channel_select_ff <= 4'h0;
      ctrl1_ff <= {`ADCSEQ_CTRL1_W{1'b0}};
      ctrl2_ff <= `ADCSEQ_RESET_BYTE;
      conversion_done_irq_flag_ff <= 1'b0;
      conversion_done_irq_enable_ff <= 1'b0;
      compare_mode_field_ff <= 4'h0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
      port_meta_ff <= {`ADCSEQ_PORT_W{1'b0}};
      port_sync_ff <= {`ADCSEQ_PORT_W{1'b0}};
      rdata_ff <= `ADCSEQ_RESET_BYTE;
      channel_sel_ff <= 4'h0;
      sample_switch_ff <= 1'b0;
      discharge_ff <= 1'b0;
      converting_ff <= 1'b0;
      pos_reference_select_ff <= 1'b0;
      neg_reference_select_ff <= 1'b0;
      trigger_timer_clear_ff <= 1'b0;
      conversion_done_irq_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
      go_ff <= nxt_go;
      conversion_done_irq_flag_ff <= nxt_flag;
      if (wr_ctrl0)
      begin
        converter_enable_ff <= wdata[`ADCSEQ_ENABLE_BIT];
        input_channel_select_ff <= wdata[`ADCSEQ_CHS_MSB:`ADCSEQ_CHS_LSB];
      end
      if (wr_en && addr == `ADCSEQ_REG_CTRL1)
        ctrl1_ff <= wdata[`ADCSEQ_CTRL1_W-1:0];
      if (wr_en && addr == `ADCSEQ_REG_CTRL2)
        ctrl2_ff <= {wdata[7], 1'b0, wdata[5:0]};
      if (wr_en && addr == `ADCSEQ_REG_IRQ)
        conversion_done_irq_enable_ff <= wdata[`ADCSEQ_IRQ_EN_BIT];
      if (wr_en && addr == `ADCSEQ_REG_CMP_MODE)
        compare_mode_field_ff <= wdata[3:0];
      cmp_meta_ff <= cmp_above;
      cmp_sync_ff <= cmp_meta_ff;
      port_meta_ff <= port_pins;
      port_sync_ff <= port_meta_ff;
      rdata_ff <= rd_en ? rd_mux : `ADCSEQ_RESET_BYTE;
      // Channel reaches the mux whatever the pin direction
      channel_sel_ff <= input_channel_select_ff;
      sample_switch_ff <= (nxt_state == ST_SAMPLE) || (nxt_state == ST_ACQ)
                          || (nxt_state == ST_DELAY);
      discharge_ff <= (nxt_state == ST_DISCH);
      converting_ff <= (nxt_state == ST_CONV);
      pos_reference_select_ff <= ctrl1_ff[`ADCSEQ_POS_REFERENCE_SELECT_BIT];
      neg_reference_select_ff <= ctrl1_ff[`ADCSEQ_NEG_REFERENCE_SELECT_BIT];
      trigger_timer_clear_ff <= event_is_trigger;
      conversion_done_irq_ff <= nxt_flag & conversion_done_irq_enable_ff;
    end
  end

  // Phase changes realign the bit period so each phase gets whole periods
  adcseq_tad_gen u_tad_gen
  (
    .clk (clk),
    .reset_n (reset_n),
    .restart (nxt_state != state_ff),
    .clk_select (conversion_clock_select),
    .tad_tick_ff (tad_tick)
  );

  adcseq_sar u_sar
  (
    .clk (clk),
    .reset_n (reset_n),
    .start (sar_start),
    .step (sar_step),
    .cmp_above (cmp_sync_ff),
    .trial_ff (dac_code)
  );

endmodule // adcseq_top

// >>> test/adcseq_top_properties.sv
`timescale 1ns/1ps
`include "adcseq_defs.vh"

module adcseq_checker
(
  input wire clk,
  input wire reset_n,
  input wire [`ADCSEQ_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata_ff,
  input wire cmp_above,
  input wire [`ADCSEQ_PORT_W-1:0] port_pins,
  input wire special_event,
  input wire [3:0] channel_sel_ff,
  input wire sample_switch_ff,
  input wire discharge_ff,
  input wire converting_ff,
  input wire [`ADCSEQ_RES_W-1:0] dac_code,
  input wire pos_reference_select_ff,
  input wire neg_reference_select_ff,
  input wire trigger_timer_clear_ff,
  input wire conversion_done_irq_ff
);
  reg [9:0] conv_cnt_ff;
  reg touched_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Any CTRL0 write during a conversion may abort it, so its minimum length is not judged
  always @(posedge clk)
  begin
    if (!reset_n || !converting_ff)
    begin
      conv_cnt_ff <= 10'h000;
      touched_ff <= 1'b0;
    end
    else
    begin
      conv_cnt_ff <= conv_cnt_ff + 10'h001;
      touched_ff <= touched_ff | (wr_en && addr == `ADCSEQ_REG_CTRL0);
    end
  end
  property p_abort;
    wr_en && addr == `ADCSEQ_REG_CTRL0 && !wdata[`ADCSEQ_GO_BIT] && converting_ff
      |-> ##[1:3] !converting_ff;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion ran on after abort");
  property p_conv_min;
    $fell(converting_ff) && !touched_ff |-> conv_cnt_ff >= 10'd22;
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion too short");
  property p_conv_max;
    conv_cnt_ff <= 10'd710;
  endproperty
  a_conv_max: assert property (p_conv_max) else $error("conversion too long");
  property p_excl;
    converting_ff |-> !sample_switch_ff && !discharge_ff;
  endproperty
  a_excl: assert property (p_excl) else $error("sampling during conversion");
  property p_disch;
    $rose(sample_switch_ff) |-> $past(discharge_ff);
  endproperty
  a_disch: assert property (p_disch) else $error("sample without discharge");
  property p_recov;
    $fell(converting_ff) |-> !sample_switch_ff [*4];
  endproperty
  a_recov: assert property (p_recov) else $error("sampling resumed too early");
  property p_tclr;
    trigger_timer_clear_ff |-> $past(special_event);
  endproperty
  a_tclr: assert property (p_tclr) else $error("timer clear without event");
  property p_irq;
    $rose(conversion_done_irq_ff) |-> $past(converting_ff) || $past(converting_ff, 2)
      || $past(wr_en) || $past(wr_en, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("flag rose without completion");
  property p_chan;
    $past(wr_en && addr == `ADCSEQ_REG_CTRL0, 2) |-> channel_sel_ff == $past(wdata[5:2], 2);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select not applied");
  property p_rdata;
    !$past(rd_en) |-> rdata_ff == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule // adcseq_checker

bind adcseq_top adcseq_checker u_chk (.clk(clk), .reset_n(reset_n), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_ff(rdata_ff), .cmp_above(cmp_above),
  .port_pins(port_pins), .special_event(special_event), .channel_sel_ff(channel_sel_ff),
  .sample_switch_ff(sample_switch_ff), .discharge_ff(discharge_ff),
  .converting_ff(converting_ff), .dac_code(dac_code),
  .pos_reference_select_ff(pos_reference_select_ff),
  .neg_reference_select_ff(neg_reference_select_ff),
  .trigger_timer_clear_ff(trigger_timer_clear_ff),
  .conversion_done_irq_ff(conversion_done_irq_ff));

// >>> test/test_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "adcseq_defs.vh"

module test_adc_conversion_sequencer;
  reg clk, reset_n, wr_en, rd_en, cmp_above, special_event;
  reg [3:0] addr, ch;
  reg [7:0] wdata, v, r1, r2;
  reg [15:0] port_pins, p;
  reg [9:0] vin;
  wire [7:0] rdata_ff;
  wire [3:0] channel_sel_ff;
  wire [9:0] dac_code;
  wire sample_switch_ff, discharge_ff, converting_ff, pos_sel, neg_sel, tclr, irq;
  int n_mismatch, total_checks, n, seed;
  logic c1;

  adcseq_top uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_ff(rdata_ff), .cmp_above(cmp_above), .port_pins(port_pins),
    .special_event(special_event), .channel_sel_ff(channel_sel_ff),
    .sample_switch_ff(sample_switch_ff), .discharge_ff(discharge_ff),
    .converting_ff(converting_ff), .dac_code(dac_code), .pos_reference_select_ff(pos_sel),
    .neg_reference_select_ff(neg_sel), .trigger_timer_clear_ff(tclr),
    .conversion_done_irq_ff(irq));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Ideal comparator with no offset, so a trial equal to the input is kept
  always @(posedge clk) cmp_above <= (vin >= dac_code);

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task inr(input int lo, input int hi);
    check({15'h0, n >= lo && n <= hi}, 16'h1);
  endtask

  task wr(input [3:0] a, input [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task rchk(input [3:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata_ff, e);
  endtask

  // Pins AN0 upward stay analog, one fewer for each step of the config code
  function logic [15:0] port_exp(input logic [15:0] pins, input int cfg);
    for (int k = 0; k < 16; k++)
      port_exp[k] = (k < 16 - cfg) ? 1'b0 : pins[k];
  endfunction

  function logic pick(input int s);
    pick = (s == 0) ? converting_ff : sample_switch_ff;
  endfunction

  task wait_for(input int s, input logic lvl);
    n = 0;
    #1;
    while (pick(s) !== lvl)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 3000)
      begin
        $display("BAD %0t wait ran out", $time);
        n_mismatch++;
        stop_test;
      end
    end
  endtask

  // Bit periods of 4 clocks or more cover the synchroniser lag on the comparator
  task conv(input [2:0] acqt, input j, input [2:0] cs, input int d, input int alo,
            input int ahi);
    vin = 10'($urandom);
    ch = 4'($urandom);
    wr(`ADCSEQ_REG_CTRL2, {j, 1'b0, acqt, cs});
    wait_for(1, 1'b1);
    wr(`ADCSEQ_REG_CTRL0, {2'b00, ch, 2'b11});
    wait_for(0, 1'b1);
    inr(alo, ahi);
    wait_for(0, 1'b0);
    inr(11 * d, 11 * d + 12);
    check(irq, 1'b1);
    wait_for(1, 1'b1);
    inr(2 * d, 3 * d + 16);
    rchk(`ADCSEQ_REG_RES_HI, j ? {6'h00, vin[9:8]} : vin[9:2]);
    rchk(`ADCSEQ_REG_RES_LO, j ? vin[7:0] : {vin[1:0], 6'h00});
    rchk(`ADCSEQ_REG_CTRL0, {2'b00, ch, 2'b01});
    rchk(`ADCSEQ_REG_IRQ, 8'h03);
    wr(`ADCSEQ_REG_IRQ, 8'h02);
  endtask

  initial
  begin
    reset_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    special_event = 1'b0;
    cmp_above = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    port_pins = 16'h0000;
    vin = 10'h000;
    n_mismatch = 0;
    total_checks = 0;
    seed = $urandom(32'h26f4f1d9);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 16; a++)
      rchk(4'(a), 8'h00);
    wr(`ADCSEQ_REG_CTRL2, 8'hff);
    rchk(`ADCSEQ_REG_CTRL2, 8'hbf);
    wr(4'h9, 8'hff);
    rchk(4'h9, 8'h00);
    wr(`ADCSEQ_REG_CTRL0, 8'h3e);
    rchk(`ADCSEQ_REG_CTRL0, 8'h3c);
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      port_pins <= 16'($urandom);
      wr(`ADCSEQ_REG_CTRL1, v);
      rchk(`ADCSEQ_REG_CTRL1, v & 8'h3f);
      check({neg_sel, pos_sel}, v[5:4]);
      p = port_exp(port_pins, v[3:0]);
      rchk(`ADCSEQ_REG_PORT_LO, p[7:0]);
      rchk(`ADCSEQ_REG_PORT_HI, p[15:8]);
    end
    wr(`ADCSEQ_REG_IRQ, 8'h02);
    wr(`ADCSEQ_REG_CTRL0, 8'h01);
    conv(3'h0, 1'b0, 3'h1, 8, 3, 8);
    conv(3'h2, 1'b1, 3'h1, 8, 32, 45);
    conv(3'h1, 1'b0, 3'h3, `ADCSEQ_RC_TAD_CLKS, 60, 75);
    conv(3'h7, 1'b1, 3'h4, 4, 80, 95);
    conv(3'h0, 1'b1, 3'h1, 8, 3, 8);
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    wr(`ADCSEQ_REG_RES_HI, r1);
    wr(`ADCSEQ_REG_RES_LO, r2);
    wr(`ADCSEQ_REG_CTRL0, 8'h03);
    wait_for(0, 1'b1);
    repeat (20) @(posedge clk);
    wr(`ADCSEQ_REG_CTRL0, 8'h01);
    wait_for(0, 1'b0);
    inr(0, 3);
    wait_for(1, 1'b1);
    inr(16, 40);
    rchk(`ADCSEQ_REG_RES_HI, r1);
    rchk(`ADCSEQ_REG_RES_LO, r2);
    rchk(`ADCSEQ_REG_IRQ, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADCSEQ_REG_CMP_MODE, i[1] ? 8'h0b : 8'h0a);
      wr(`ADCSEQ_REG_CTRL0, {7'h00, i[0]});
      if (i[0])
        wait_for(1, 1'b1);
      @(posedge clk);
      special_event <= 1'b1;
      @(posedge clk);
      special_event <= 1'b0;
      #1 c1 = tclr;
      @(posedge clk);
      #1 c1 = c1 | tclr;
      check(c1, i[1]);
      if (i == 3)
      begin
        wait_for(0, 1'b1);
        inr(0, 45);
        wait_for(0, 1'b0);
      end
      else
        rchk(`ADCSEQ_REG_CTRL0, {7'h00, i[0]});
    end
    stop_test;
  end
endmodule // test_adc_conversion_sequencer
